// >>> rtl/usb_ep0_ctrl.sv
// endpoint-0 control and status registers with link handshakes
// Operation
// - In device mode a one written to low bit 7 clears the setup-end flag, nothing else does.
// - In device mode a one written to low bit 6 clears the receive-ready flag.
// - In device mode a one written to low bit 5 requests a stall, cleared once it is sent.
// - Setup-end sets when a control transfer aborts before last-data, with event and flush.
// - Last-data is set by software with the final packet and cleared by the hardware.
// - Stalled sets when a stall is sent, a written zero clears it and a one does nothing.
// - Transmit-ready is set by software and cleared with an event once the packet is sent.
// - Receive-ready sets with an event on a packet and clears only by software request.
// - In host mode a one to high bit 2 enables one toggle write and then clears itself.
// - In host mode high bit 1 reads the toggle and is writable only while enabled.
// - A one to high bit 0 flushes the fifo and clears transmit-ready and receive-ready.
// - Both registers are 8 bits, reset to zero, and reserved bits read as zero.
`timescale 1ns/1ps
module usb_ep0_ctrl (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire usb_ep0_pkg::link_in_s  lnk,
    output usb_ep0_pkg::link_out_s      lout,
    output logic                     irq
);
    usb_ep0_pkg::bus_req_s             req;
    logic [31:0]                       rd_value;
    logic [usb_ep0_pkg::NUM_EV-1:0]    ev;
    logic [usb_ep0_pkg::NUM_EV-1:0]    ev_status;
    logic [usb_ep0_pkg::NUM_EV-1:0]    ev_mask;
    logic                              host_r;
    logic                              setup_end_r;
    logic                              rx_ready_r;
    logic                              tx_ready_r;
    logic                              stall_req_r;
    logic                              stalled_r;
    logic                              last_data_r;
    logic                              twe_r;
    logic                              toggle_r;
    logic                              flush_r;
    logic                              dev;
    logic                              wr_lo;
    logic                              wr_hi;
    logic [7:0]                        wd;
    logic                              ev_setup_end;
    logic                              flush_now;
    logic                              rx_clr;
    logic                              tx_set;
    logic                              stall_set;

    function automatic logic hit(input usb_ep0_pkg::bus_req_s r,
                                 input logic [usb_ep0_pkg::IDX_W-1:0] idx);
        hit = r.wr && (r.idx == idx);
    endfunction

    ep0_ahb_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .req       (req),
        .rd_value  (rd_value)
    );

    ep0_irq u_irq (
        .hclk    (hclk),
        .hresetn (hresetn),
        .events  (ev),
        .stat_we (hit(req, usb_ep0_pkg::IDX_IRQ_STAT)),
        .mask_we (hit(req, usb_ep0_pkg::IDX_IRQ_MASK)),
        .wdata   (req.wdata[usb_ep0_pkg::NUM_EV-1:0]),
        .status  (ev_status),
        .mask    (ev_mask),
        .irq     (irq)
    );

    // write decode by mode
    assign dev          = !host_r;
    assign wr_lo        = hit(req, usb_ep0_pkg::IDX_CSR_LOW);
    assign wr_hi        = hit(req, usb_ep0_pkg::IDX_CSR_HIGH);
    assign wd           = req.wdata[7:0];
    assign ev_setup_end = dev && lnk.ctrl_abort && !last_data_r;
    assign flush_now    = wr_hi && wd[usb_ep0_pkg::HI_FLUSH];
    assign tx_set       = wr_lo && wd[usb_ep0_pkg::LO_TX_READY];
    assign stall_set    = dev && wr_lo && wd[usb_ep0_pkg::LO_STALL];
    assign rx_clr       = wr_lo && (dev ? wd[usb_ep0_pkg::LO_RX_CLR]
                                        : !wd[usb_ep0_pkg::LO_RX_READY]);

    assign ev[usb_ep0_pkg::EV_TX]        = lnk.tx_pkt_done && tx_ready_r;
    assign ev[usb_ep0_pkg::EV_RX]        = lnk.rx_pkt_done;
    assign ev[usb_ep0_pkg::EV_SETUP_END] = ev_setup_end;
    assign ev[usb_ep0_pkg::EV_STALL]     = dev && lnk.stall_sent;

    // operating mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_r <= 1'b0;
        end else if (hit(req, usb_ep0_pkg::IDX_MODE)) begin
            host_r <= req.wdata[usb_ep0_pkg::MODE_HOST];
        end
    end

    // setup end flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            setup_end_r <= 1'b0;
        end else if (ev_setup_end) begin
            setup_end_r <= 1'b1;
        end else if (dev && wr_lo && wd[usb_ep0_pkg::LO_SETUP_CLR]) begin
            setup_end_r <= 1'b0;
        end
    end

    // receive ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_ready_r <= 1'b0;
        end else if (lnk.rx_pkt_done) begin
            rx_ready_r <= 1'b1;
        end else if (rx_clr || flush_now) begin
            rx_ready_r <= 1'b0;
        end
    end

    // transmit ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_ready_r <= 1'b0;
        end else if (tx_set) begin
            tx_ready_r <= 1'b1;
        end else if (lnk.tx_pkt_done || flush_now) begin
            tx_ready_r <= 1'b0;
        end
    end

    // stall request and stalled flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stall_req_r <= 1'b0;
        end else if (stall_set) begin
            stall_req_r <= 1'b1;
        end else if (lnk.stall_sent) begin
            stall_req_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stalled_r <= 1'b0;
        end else if (dev && lnk.stall_sent) begin
            stalled_r <= 1'b1;
        end else if (dev && wr_lo && !wd[usb_ep0_pkg::LO_STALLED]) begin
            stalled_r <= 1'b0;
        end
    end

    // last data mark
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_data_r <= 1'b0;
        end else if (dev && wr_lo && wd[usb_ep0_pkg::LO_LAST_DATA]) begin
            last_data_r <= 1'b1;
        end else if (lnk.status_done || lnk.ctrl_abort) begin
            last_data_r <= 1'b0;
        end
    end

    // toggle write enable and data toggle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            twe_r <= 1'b0;
        end else if (host_r && wr_hi && twe_r) begin
            twe_r <= 1'b0;
        end else if (host_r && wr_hi && wd[usb_ep0_pkg::HI_TWE]) begin
            twe_r <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            toggle_r <= 1'b0;
        end else if (host_r && wr_hi && twe_r) begin
            toggle_r <= wd[usb_ep0_pkg::HI_TOGGLE];
        end else if (lnk.toggle_flip) begin
            toggle_r <= !toggle_r;
        end
    end

    // fifo flush pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flush_r <= 1'b0;
        end else begin
            flush_r <= flush_now || ev_setup_end;
        end
    end

    // read mux
    always_comb begin
        rd_value = usb_ep0_pkg::RD_ZERO;
        unique case (req.idx)
            usb_ep0_pkg::IDX_CSR_LOW: begin
                rd_value[usb_ep0_pkg::LO_TX_READY] = tx_ready_r;
                rd_value[usb_ep0_pkg::LO_RX_READY] = rx_ready_r;
                if (dev) begin
                    rd_value[usb_ep0_pkg::LO_STALL]     = stall_req_r;
                    rd_value[usb_ep0_pkg::LO_SETUP_END] = setup_end_r;
                    rd_value[usb_ep0_pkg::LO_LAST_DATA] = last_data_r;
                    rd_value[usb_ep0_pkg::LO_STALLED]   = stalled_r;
                end
            end
            usb_ep0_pkg::IDX_CSR_HIGH: begin
                if (host_r) begin
                    rd_value[usb_ep0_pkg::HI_TWE]    = twe_r;
                    rd_value[usb_ep0_pkg::HI_TOGGLE] = toggle_r;
                end
            end
            usb_ep0_pkg::IDX_IRQ_STAT: rd_value[usb_ep0_pkg::NUM_EV-1:0] = ev_status;
            usb_ep0_pkg::IDX_IRQ_MASK: rd_value[usb_ep0_pkg::NUM_EV-1:0] = ev_mask;
            usb_ep0_pkg::IDX_MODE:     rd_value[usb_ep0_pkg::MODE_HOST] = host_r;
            default:                   rd_value = usb_ep0_pkg::RD_ZERO;
        endcase
    end

    // link outputs
    always_comb begin
        lout.host_mode   = host_r;
        lout.tx_ready    = tx_ready_r;
        lout.stall_req   = stall_req_r;
        lout.fifo_flush  = flush_r;
        lout.data_toggle = toggle_r;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    setup_clear_a: assert property (
        dev && wr_lo && wd[usb_ep0_pkg::LO_SETUP_CLR] && !ev_setup_end |=> !setup_end_r)
        else $error("setup end not cleared");
    rx_clear_a: assert property (
        dev && wr_lo && wd[usb_ep0_pkg::LO_RX_CLR] && !lnk.rx_pkt_done |=> !rx_ready_r)
        else $error("rx ready not cleared");
    stall_done_a: assert property (
        lnk.stall_sent && !stall_set |=> !lout.stall_req)
        else $error("stall request stuck after stall sent");
    abort_flush_a: assert property (
        ev_setup_end
        |=> setup_end_r && lout.fifo_flush && ev_status[usb_ep0_pkg::EV_SETUP_END])
        else $error("setup end without flush or event");
    last_data_a: assert property (
        lnk.status_done && !(dev && wr_lo && wd[usb_ep0_pkg::LO_LAST_DATA]) |=> !last_data_r)
        else $error("last data mark not cleared");
    stalled_keep_a: assert property (
        stalled_r && wr_lo && wd[usb_ep0_pkg::LO_STALLED] |=> stalled_r)
        else $error("stalled cleared by writing one");
    tx_done_a: assert property (
        lnk.tx_pkt_done && tx_ready_r && !tx_set
        |=> !lout.tx_ready && ev_status[usb_ep0_pkg::EV_TX])
        else $error("tx ready not cleared with event");
    rx_set_a: assert property (
        lnk.rx_pkt_done |=> rx_ready_r && ev_status[usb_ep0_pkg::EV_RX])
        else $error("rx ready not set with event");
    twe_once_a: assert property (
        host_r && wr_hi && twe_r |=> !twe_r)
        else $error("toggle enable not cleared after write");
    toggle_lock_a: assert property (
        host_r && wr_hi && !twe_r && !lnk.toggle_flip |=> $stable(toggle_r))
        else $error("toggle written without enable");
    flush_clear_a: assert property (
        flush_now && !tx_set && !lnk.rx_pkt_done
        |=> lout.fifo_flush && !tx_ready_r && !rx_ready_r)
        else $error("flush did not clear ready flags");
    reserved_zero_a: assert property (
        req.rd && dev && req.idx == usb_ep0_pkg::IDX_CSR_HIGH ##1 hreadyout
        |-> hrdata == usb_ep0_pkg::RD_ZERO)
        else $error("device high register not zero");
    host_nostall_a: assert property (
        host_r && wr_lo && !stall_req_r |=> !stall_req_r)
        else $error("stall requested in host mode");
endmodule

// >>> rtl/usb_ep0_pkg.sv
// constants and carrier types for the endpoint-0 control and status block
package usb_ep0_pkg;
    localparam int unsigned IDX_W  = 10;
    localparam int unsigned NUM_EV = 4;

    // register indexes, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CSR_LOW  = 10'h102;
    localparam logic [IDX_W-1:0] IDX_CSR_HIGH = 10'h103;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h104;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h105;
    localparam logic [IDX_W-1:0] IDX_MODE     = 10'h106;

    // low register fields
    localparam int unsigned LO_SETUP_CLR  = 7;
    localparam int unsigned LO_RX_CLR     = 6;
    localparam int unsigned LO_STALL      = 5;
    localparam int unsigned LO_SETUP_END  = 4;
    localparam int unsigned LO_LAST_DATA  = 3;
    localparam int unsigned LO_STALLED    = 2;
    localparam int unsigned LO_TX_READY   = 1;
    localparam int unsigned LO_RX_READY   = 0;

    // high register fields
    localparam int unsigned HI_TWE    = 2;
    localparam int unsigned HI_TOGGLE = 1;
    localparam int unsigned HI_FLUSH  = 0;

    // mode register field
    localparam int unsigned MODE_HOST = 0;

    // interrupt event bits
    localparam int unsigned EV_TX        = 0;
    localparam int unsigned EV_RX        = 1;
    localparam int unsigned EV_SETUP_END = 2;
    localparam int unsigned EV_STALL     = 3;

    localparam logic [7:0]        CSR_RESET = 8'h00;
    localparam logic [NUM_EV-1:0] EV_RESET  = 4'h0;
    localparam logic [31:0]       RD_ZERO   = 32'h0000_0000;

    typedef struct packed {
        logic rx_pkt_done;
        logic tx_pkt_done;
        logic stall_sent;
        logic ctrl_abort;
        logic status_done;
        logic toggle_flip;
    } link_in_s;

    typedef struct packed {
        logic host_mode;
        logic tx_ready;
        logic stall_req;
        logic fifo_flush;
        logic data_toggle;
    } link_out_s;

    typedef struct packed {
        logic             wr;
        logic             rd;
        logic [IDX_W-1:0] idx;
        logic [31:0]      wdata;
    } bus_req_s;
endpackage

// >>> rtl/ep0_ahb_slave.sv
// ahb-lite slave front end, one wait state per transfer
`timescale 1ns/1ps
module ep0_ahb_slave (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    output usb_ep0_pkg::bus_req_s    req,
    input  wire logic [31:0]         rd_value
);
    logic                          pend_r;
    logic                          pend_wr_r;
    logic [usb_ep0_pkg::IDX_W-1:0] pend_idx_r;
    logic                          take;

    assign take = hsel && htrans[1] && hready && (hsize == 3'h2);

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r     <= 1'b0;
            pend_wr_r  <= 1'b0;
            pend_idx_r <= '0;
            hreadyout  <= 1'b1;
        end else begin
            pend_r    <= take;
            hreadyout <= !take;
            if (take) begin
                pend_wr_r  <= hwrite;
                pend_idx_r <= haddr[usb_ep0_pkg::IDX_W+1:2];
            end
        end
    end

    // data phase: write strobe and read capture
    always_comb begin
        req.wr    = pend_r && pend_wr_r;
        req.rd    = pend_r && !pend_wr_r;
        req.idx   = pend_idx_r;
        req.wdata = hwdata;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= usb_ep0_pkg::RD_ZERO;
            hresp  <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (req.rd) begin
                hrdata <= rd_value;
            end
        end
    end
endmodule

// >>> rtl/ep0_irq.sv
// sticky event status, mask and level interrupt
`timescale 1ns/1ps
module ep0_irq (
    input  wire logic                           hclk,
    input  wire logic                           hresetn,
    input  wire logic [usb_ep0_pkg::NUM_EV-1:0] events,
    input  wire logic                           stat_we,
    input  wire logic                           mask_we,
    input  wire logic [usb_ep0_pkg::NUM_EV-1:0] wdata,
    output logic [usb_ep0_pkg::NUM_EV-1:0]      status,
    output logic [usb_ep0_pkg::NUM_EV-1:0]      mask,
    output logic                                irq
);
    // write one clears, a new event wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= usb_ep0_pkg::EV_RESET;
        end else begin
            status <= (status & ~(stat_we ? wdata : usb_ep0_pkg::EV_RESET)) | events;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= usb_ep0_pkg::EV_RESET;
        end else if (mask_we) begin
            mask <= wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end
endmodule

// >>> bench/ep0_link_partner.sv
// usb link partner model facing endpoint 0
`timescale 1ns/1ps
module ep0_link_partner (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire usb_ep0_pkg::link_out_s lout,
    input  wire logic [3:0]             cmd,
    input  wire logic [3:0]             lat,
    output usb_ep0_pkg::link_in_s       lnk
);
    logic [3:0] tx_cnt;
    logic [3:0] st_cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lnk <= '0;
            tx_cnt <= 4'h0;
            st_cnt <= 4'h0;
        end else begin
            lnk.rx_pkt_done <= cmd[0];
            lnk.ctrl_abort <= cmd[1];
            lnk.status_done <= cmd[2];
            lnk.toggle_flip <= cmd[3];
            // packet leaves lat+1 cycles after transmit-ready
            tx_cnt <= (lout.tx_ready && !lnk.tx_pkt_done) ? tx_cnt + 4'h1 : 4'h0;
            lnk.tx_pkt_done <= lout.tx_ready && !lnk.tx_pkt_done && tx_cnt >= lat;
            // stall handshake lat+1 cycles after request
            st_cnt <= (lout.stall_req && !lnk.stall_sent) ? st_cnt + 4'h1 : 4'h0;
            lnk.stall_sent <= lout.stall_req && !lnk.stall_sent && st_cnt >= lat;
        end
    end
endmodule

// >>> bench/tb.sv
// self-checking bench for the endpoint-0 control and status block
`timescale 1ns/1ps
module tb;
    logic                   hclk    = 1'b0;
    logic                   hresetn = 1'b0;
    logic                   hsel    = 1'b0;
    logic [31:0]            haddr   = 32'h0;
    logic [1:0]             htrans  = 2'h0;
    logic                   hwrite  = 1'b0;
    logic [31:0]            hwdata  = 32'h0;
    logic [3:0]             cmd     = 4'h0;
    logic [3:0]             lat     = 4'h2;
    logic                   hready;
    logic                   hresp;
    logic [31:0]            hrdata;
    logic                   irq;
    usb_ep0_pkg::link_in_s  lnk;
    usb_ep0_pkg::link_out_s lout;
    int                     fails   = 0;
    int                     checked = 0;
    int                     nflush  = 0;
    int                     eflush  = 0;
    bit                     rx, tx, suend, dend, stld, stall, tog, twe, host;
    bit [3:0]               stat, mask;

    always #12.5 hclk = ~hclk;

    usb_ep0_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .lnk(lnk), .lout(lout), .irq(irq));

    ep0_link_partner partner (.hclk(hclk), .hresetn(hresetn), .lout(lout), .cmd(cmd),
        .lat(lat), .lnk(lnk));

    // reference model follows the link events
    always @(posedge hclk) begin
        if (hresetn) begin
            if (lout.fifo_flush === 1'b1)
                nflush++;
            if (lnk.rx_pkt_done) begin
                rx = 1'b1;
                stat[1] = 1'b1;
            end
            if (lnk.tx_pkt_done && tx) begin
                tx = 1'b0;
                stat[0] = 1'b1;
            end
            if (lnk.stall_sent)
                stall = 1'b0;
            if (lnk.stall_sent && !host) begin
                stld = 1'b1;
                stat[3] = 1'b1;
            end
            if (lnk.ctrl_abort && !host && !dend) begin
                suend = 1'b1;
                stat[2] = 1'b1;
                eflush++;
            end
            if (lnk.ctrl_abort || lnk.status_done)
                dend = 1'b0;
            if (lnk.toggle_flip)
                tog = !tog;
        end
    end

    task automatic end_sim();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1) begin
            fails++;
            end_sim();
        end
    endtask

    task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, idx, 2'h0};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        xfer(1'b1, idx, {24'h0, d}, rd);
        case (idx)
            usb_ep0_pkg::IDX_CSR_LOW:
                if (host) begin
                    tx |= d[1];
                    rx &= d[0];
                end else begin
                    suend &= !d[7];
                    rx &= !d[6];
                    stall |= d[5];
                    dend |= d[3];
                    stld &= d[2];
                    tx |= d[1];
                end
            usb_ep0_pkg::IDX_CSR_HIGH: begin
                if (host && twe) begin
                    tog = d[1];
                    twe = 1'b0;
                end else if (host)
                    twe = d[2];
                if (d[0]) begin
                    tx = 1'b0;
                    rx = 1'b0;
                    eflush++;
                end
            end
            usb_ep0_pkg::IDX_IRQ_STAT: stat &= ~d[3:0];
            usb_ep0_pkg::IDX_IRQ_MASK: mask = d[3:0];
            usb_ep0_pkg::IDX_MODE: host = d[0];
            default: ;
        endcase
    endtask

    function automatic logic [31:0] exp_rd(input logic [9:0] idx);
        case (idx)
            usb_ep0_pkg::IDX_CSR_LOW:
                return host ? {30'h0, tx, rx} : {26'h0, stall, suend, dend, stld, tx, rx};
            usb_ep0_pkg::IDX_CSR_HIGH: return host ? {29'h0, twe, tog, 1'h0} : 32'h0;
            usb_ep0_pkg::IDX_IRQ_STAT: return {28'h0, stat};
            usb_ep0_pkg::IDX_IRQ_MASK: return {28'h0, mask};
            default: return 32'h0;
        endcase
    endfunction

    task automatic chk_all();
        logic [31:0] rd;
        logic [9:0]  idx [5];
        idx = '{usb_ep0_pkg::IDX_CSR_LOW, usb_ep0_pkg::IDX_CSR_HIGH,
                usb_ep0_pkg::IDX_IRQ_STAT, usb_ep0_pkg::IDX_IRQ_MASK, 10'h107};
        foreach (idx[i]) begin
            xfer(1'b0, idx[i], 32'h0, rd);
            chk($sformatf("reg %0h", idx[i]), rd, exp_rd(idx[i]));
        end
        chk("resp", 32'(hresp), 32'h0);
        chk("irq", 32'(irq), 32'(|(stat & mask)));
        chk("tx_ready", 32'(lout.tx_ready), 32'(tx));
        chk("stall_req", 32'(lout.stall_req), 32'(stall));
        chk("toggle", 32'(lout.data_toggle), 32'(tog));
        chk("mode", 32'(lout.host_mode), 32'(host));
        chk("flushes", 32'(nflush), 32'(eflush));
    endtask

    task automatic pulse(input int k);
        cmd[k] <= 1'b1;
        @(posedge hclk);
        cmd <= 4'h0;
        tick(3);
    endtask

    task automatic quiet();
        int k;
        for (k = 0; k < 40 && (lout.tx_ready !== 1'b0 || lout.stall_req !== 1'b0); k++)
            @(posedge hclk);
        if (k == 40) begin
            fails++;
            end_sim();
        end
        tick(3);
    endtask

    initial begin
        void'($urandom(93560));
        tick(2);
        hresetn <= 1'b1;
        chk_all();
        wr(usb_ep0_pkg::IDX_IRQ_MASK, 8'h0F);
        pulse(0);
        chk_all();
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'h40);
        wr(usb_ep0_pkg::IDX_IRQ_STAT, 8'h0F);
        chk_all();
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'h0A);
        quiet();
        chk_all();
        pulse(2);
        chk_all();
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'h20);
        quiet();
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'h04);
        chk_all();
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'h00);
        chk_all();
        pulse(1);
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'h00);
        chk_all();
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'h80);
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'h08);
        pulse(1);
        chk_all();
        pulse(0);
        wr(usb_ep0_pkg::IDX_CSR_HIGH, 8'h01);
        chk_all();
        wr(usb_ep0_pkg::IDX_MODE, 8'h01);
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'hFF);
        quiet();
        chk_all();
        wr(usb_ep0_pkg::IDX_CSR_HIGH, 8'h02);
        wr(usb_ep0_pkg::IDX_CSR_HIGH, 8'h04);
        chk_all();
        wr(usb_ep0_pkg::IDX_CSR_HIGH, 8'h06);
        pulse(0);
        chk_all();
        pulse(3);
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'h00);
        chk_all();
        lat <= 4'hF;
        wr(usb_ep0_pkg::IDX_CSR_LOW, 8'h02);
        wr(usb_ep0_pkg::IDX_CSR_HIGH, 8'h01);
        chk_all();
        wr(usb_ep0_pkg::IDX_MODE, 8'h00);
        repeat (20) begin
            lat <= 4'($urandom_range(15));
            wr(usb_ep0_pkg::IDX_IRQ_MASK, 8'($urandom));
            wr(usb_ep0_pkg::IDX_CSR_LOW, 8'($urandom));
            quiet();
            chk_all();
            wr(usb_ep0_pkg::IDX_IRQ_STAT, 8'h0F);
        end
        end_sim();
    end
endmodule
